//--- core/bcs_top.sv
// boot chip-select decode, wait-state acknowledge and bus control pins
// assumes pins arrive asynchronously and core events come from the same clock
`timescale 1ns/10ps
`default_nettype none
module bcs_top
   import bcs_pkg::*;
#(
   parameter int WDOG_LIMIT = WDOG_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [23:0] bus_addr,
   input wire logic addr_strobe_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic bus_width_select,
   input wire logic core_disable_pin,
   input wire logic stop_pin_in,
   input wire logic reset_pin_in,
   input wire logic core_stop_instr,
   input wire logic core_reset_instr,
   input wire logic independent_dma,
   input wire logic serial_channel_dma,
   input wire logic serial_dma_request,
   input wire logic irq_pending,
   input wire logic bus_clear_irq_en,
   input wire logic ext_request_level7,
   input wire logic ext_request_level6,
   input wire logic ext_request_level1,
   input wire logic [3:0] port_b_req,
   input wire logic sel_write,
   input wire logic [1:0] sel_target,
   input wire logic [23:0] sel_base,
   input wire logic [23:0] sel_mask,
   input wire logic sel_enable,
   input wire logic [3:0] sel_wait,
   input wire logic periph_base_write,
   input wire logic [11:0] periph_base_value,
   input wire logic periph_access,
   output logic boot_select_n,
   output logic ram_select_n,
   output logic transfer_ack_n,
   output logic bus_fault_n,
   output logic bus_fault_oe,
   output logic dma_grant_ack_n,
   output logic bus_clear_n,
   output logic bus_clear_oe,
   output logic stop_pin_out,
   output logic stop_pin_oe,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic core_run,
   output logic wide_bus,
   output logic periph_respond,
   output logic [11:0] periph_base,
   output logic [15:0] core_status_word,
   output logic [6:0] request_sources,
   output logic [7:0] int_vector,
   output logic int_vector_valid,
   output logic [3:0] bus_state_dbg
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [14:0] pin_s1_q;
   logic [14:0] pin_s2_q;
   logic [14:0] pin_raw;
   assign pin_raw = {addr_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, bus_width_select,
      core_disable_pin, stop_pin_in, reset_pin_in, ext_request_level7, ext_request_level6,
      ext_request_level1, port_b_req, 1'b0};
   always_ff @(posedge core_clk)
   begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
   end
   logic as_n_s;
   logic uds_n_s;
   logic lds_n_s;
   logic bus_width_select_s;
   logic cdis_s;
   logic stop_in_s;
   logic rst_in_s;
   logic [6:0] req_s;
   assign as_n_s = pin_s2_q[14];
   assign uds_n_s = pin_s2_q[13];
   assign lds_n_s = pin_s2_q[12];
   assign bus_width_select_s = pin_s2_q[11];
   assign cdis_s = pin_s2_q[10];
   assign stop_in_s = pin_s2_q[9];
   assign rst_in_s = pin_s2_q[8];
   assign req_s = pin_s2_q[7:1];

   // ------------------------------------------------------------
   // combined reset
   // ------------------------------------------------------------
   logic ext_both;
   logic any_rst;
   logic stop_oe_q;
   logic rst_oe_q;
   // only count the pins as external reset when we are not driving them
   assign ext_both = !stop_in_s && !rst_in_s && !stop_oe_q && !rst_oe_q;
   assign any_rst = rst || ext_both;

   // ------------------------------------------------------------
   // chip-select windows
   // ------------------------------------------------------------
   logic [23:0] boot_base_q;
   logic [23:0] boot_mask_q;
   logic boot_en_q;
   logic [3:0] boot_wait_q;
   logic [23:0] ram_base_q;
   logic [23:0] ram_mask_q;
   logic ram_en_q;
   logic [3:0] ram_wait_q;
   logic wr_boot;
   logic wr_ram;
   assign wr_boot = sel_write && (sel_target == 2'h0);
   assign wr_ram = sel_write && (sel_target == 2'h1);
   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         boot_base_q <= BOOT_BASE_RST;
         boot_mask_q <= BOOT_MASK_RST;
         boot_en_q <= 1'b1;
         boot_wait_q <= WAIT_RST;
         ram_base_q <= RAM_BASE_RST;
         ram_mask_q <= RAM_MASK_RST;
         ram_en_q <= 1'b0;
         ram_wait_q <= WAIT_RST;
      end
      else if (wr_boot)
      begin
         boot_base_q <= sel_base;
         boot_mask_q <= sel_mask;
         boot_en_q <= sel_enable;
         boot_wait_q <= sel_wait;
      end
      else if (wr_ram)
      begin
         ram_base_q <= sel_base;
         ram_mask_q <= sel_mask;
         ram_en_q <= sel_enable;
         ram_wait_q <= sel_wait;
      end
   end
   bcs_dec_if boot_if ();
   bcs_dec_if ram_if ();
   assign boot_if.addr = bus_addr;
   assign boot_if.base = boot_base_q;
   assign boot_if.mask = boot_mask_q;
   assign boot_if.enable = boot_en_q;
   assign ram_if.addr = bus_addr;
   assign ram_if.base = ram_base_q;
   assign ram_if.mask = ram_mask_q;
   assign ram_if.enable = ram_en_q;
   bcs_window u_boot (.win(boot_if.dec));
   bcs_window u_ram (.win(ram_if.dec));

   // ------------------------------------------------------------
   // peripheral base
   // ------------------------------------------------------------
   logic [11:0] pbase_q;
   logic pbase_set_q;
   logic periph_hit;
   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         pbase_q <= 12'h000;
         pbase_set_q <= 1'b0;
      end
      else if (periph_base_write)
      begin
         pbase_q <= periph_base_value;
         pbase_set_q <= 1'b1;
      end
   end
   assign periph_hit = periph_access && pbase_set_q && (bus_addr[23:12] == pbase_q);
   logic boot_hit;
   logic ram_hit;
   // on-chip space is never decoded as external memory
   assign boot_hit = boot_if.hit && !periph_hit;
   assign ram_hit = ram_if.hit && !boot_if.hit && !periph_hit;

   // ------------------------------------------------------------
   // bus cycle sequencer and wait states
   // ------------------------------------------------------------
   bcs_bus_state_type st_q;
   bcs_bus_state_type st_d;
   logic [3:0] wcnt_q;
   logic [3:0] wload;
   logic sel_boot_q;
   logic sel_ram_q;
   logic [15:0] wdog_q;
   logic wdog_fire;
   assign wload = boot_hit ? boot_wait_q : ram_wait_q;
   assign wdog_fire = (wdog_q == 16'(WDOG_LIMIT - 1)) && !as_n_s;
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         BUS_IDLE: if (!as_n_s) st_d = BUS_ADDR;
         BUS_ADDR: st_d = (sel_boot_q || sel_ram_q) ? BUS_WAIT : BUS_DATA;
         BUS_WAIT: if (wcnt_q == 4'h0) st_d = BUS_END;
         BUS_DATA:
            if (as_n_s) st_d = BUS_IDLE;
            else if (wdog_fire) st_d = BUS_END;
         BUS_END: if (as_n_s) st_d = BUS_IDLE;
         default: st_d = BUS_IDLE;
      endcase
   end
   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         st_q <= BUS_IDLE;
         wcnt_q <= 4'h0;
         sel_boot_q <= 1'b0;
         sel_ram_q <= 1'b0;
         wdog_q <= 16'h0000;
      end
      else
      begin
         st_q <= st_d;
         if (st_q == BUS_IDLE && !as_n_s)
         begin
            // latch the select after the address is valid, like state two
            sel_boot_q <= boot_hit;
            sel_ram_q <= ram_hit;
            wcnt_q <= wload;
         end
         else if (st_d == BUS_IDLE)
         begin
            sel_boot_q <= 1'b0;
            sel_ram_q <= 1'b0;
         end
         if (st_q == BUS_WAIT && wcnt_q != 4'h0)
            wcnt_q <= wcnt_q - 4'h1;
         wdog_q <= (as_n_s || st_q == BUS_END) ? 16'h0000 : wdog_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // pin outputs
   // ------------------------------------------------------------
   logic ack_d;
   logic fault_d;
   logic bus_clear_n_d;
   assign ack_d = (st_q == BUS_END) && (sel_boot_q || sel_ram_q);
   assign fault_d = (st_q == BUS_DATA) && wdog_fire;
   assign bus_clear_n_d = serial_dma_request || (bus_clear_irq_en && irq_pending);
   logic fault_nx;
   assign fault_nx = fault_d || (bus_fault_oe && !as_n_s);
   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         boot_select_n <= 1'b1;
         ram_select_n <= 1'b1;
         transfer_ack_n <= 1'b1;
         bus_fault_n <= 1'b1;
         bus_fault_oe <= 1'b0;
         dma_grant_ack_n <= 1'b1;
         bus_clear_oe <= 1'b0;
         stop_oe_q <= 1'b0;
         rst_oe_q <= 1'b0;
      end
      else
      begin
         boot_select_n <= !(sel_boot_q && st_d != BUS_IDLE);
         ram_select_n <= !(sel_ram_q && st_d != BUS_IDLE);
         transfer_ack_n <= !ack_d;
         bus_fault_n <= !fault_nx;
         bus_fault_oe <= fault_nx;
         dma_grant_ack_n <= !(independent_dma || serial_channel_dma);
         bus_clear_oe <= bus_clear_n_d;
         stop_oe_q <= core_stop_instr && core_run;
         rst_oe_q <= core_reset_instr && core_run;
      end
   end
   assign bus_clear_n = 1'b0;
   assign stop_pin_out = 1'b0;
   assign stop_pin_oe = stop_oe_q;
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = rst_oe_q;

   // ------------------------------------------------------------
   // straps, status word and interrupt vectors
   // ------------------------------------------------------------
   logic [6:0] req_q;
   logic [2:0] prio;
   always_comb
   begin
      prio = 3'h0;
      for (int i = 0; i < 7; i++)
         if (req_q[i]) prio = 3'(i + 1);
   end
   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         core_run <= 1'b0;
         wide_bus <= 1'b1;
         core_status_word <= STATUS_RST;
         req_q <= 7'h00;
         int_vector <= 8'h00;
         int_vector_valid <= 1'b0;
         bus_state_dbg <= 4'h0;
      end
      else
      begin
         core_run <= !cdis_s;
         wide_bus <= bus_width_select_s;
         req_q <= ~req_s;
         int_vector <= {VEC_BASE_RST, 2'b00, prio};
         int_vector_valid <= (prio != 3'h0) && core_run;
         bus_state_dbg <= {!(uds_n_s && lds_n_s), st_q};
      end
   end
   always_ff @(posedge core_clk)
   begin
      periph_respond <= !any_rst && periph_hit;
      periph_base <= pbase_q;
      request_sources <= req_q;
   end
endmodule // bcs_top
`default_nettype wire

//--- core/bcs_window.sv
// one chip-select address window compare
// assumes the mask has ones in the compared high bits
`timescale 1ns/10ps
`default_nettype none
module bcs_window
(
   bcs_dec_if.dec win
);
   assign win.hit = win.enable && ((win.addr & win.mask) == (win.base & win.mask));
endmodule // bcs_window
`default_nettype wire

//--- pkg/bcs_dec_if.sv
// interface carrying one chip-select window between top and decoder
// assumes top and decoder share the core clock
`timescale 1ns/10ps
`default_nettype none
interface bcs_dec_if;
   logic [23:0] addr;
   logic [23:0] base;
   logic [23:0] mask;
   logic enable;
   logic hit;
   modport ctrl (output addr, output base, output mask, output enable, input hit);
   modport dec (input addr, input base, input mask, input enable, output hit);
endinterface
`default_nettype wire

//--- pkg/bcs_pkg.sv
// package for the boot chip-select and bus-control block
// assumes a single 125 MHz core clock and a synchronous active-high reset
// How it works
// - when the stalled-cycle watchdog fires, the bus fault output is pulled low to end the cycle.
// - the dma grant acknowledge output is low for the whole of every independent or serial dma cycle.
// - with core disable low the core runs, with it high the core is held off and only peripheral duty remains.
// - the whole block resets when stop and reset pins are both driven low from outside together.
// - the stop pin is driven when the core runs its stop instruction, the reset pin on its reset instruction.
// - seven external request sources, three request pins and four port-b pins, get internally supplied vectors.
// - accesses that hit an enabled chip-select range get their transfer acknowledge from the wait-state logic.
// - bus clear is driven while a serial dma channel wants the bus, and optionally while an interrupt is pending.
// - after reset only the boot select is enabled, at base zero with an 8 kbyte range.
// - the ram select leaves reset disabled until software enables it.
// - dual-port ram and peripheral registers give no answer until the peripheral base is first written.
// - at reset the core status word becomes 2700 hex, supervisor mode with all levels masked.
// - on a read the select goes low after the rising edge of state two, and memory data is due before state six.
package bcs_pkg;
   localparam int ADDR_W = 24;
   localparam int CLK_PERIOD_NS = 8;
   localparam logic [23:0] BOOT_BASE_RST = 24'h000000;
   localparam logic [23:0] BOOT_MASK_RST = 24'hFFE000;
   localparam logic [23:0] RAM_BASE_RST = 24'h000000;
   localparam logic [23:0] RAM_MASK_RST = 24'hFF0000;
   localparam logic [15:0] STATUS_RST = 16'h2700;
   localparam logic [3:0] WAIT_RST = 4'h6;
   localparam int WDOG_TIME_US = 16;
   localparam int WDOG_CYCLES = (WDOG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] VEC_BASE_RST = 3'h2;
   typedef enum logic [2:0]
   {
      BUS_IDLE = 3'b000,
      BUS_ADDR = 3'b001,
      BUS_WAIT = 3'b011,
      BUS_DATA = 3'b010,
      BUS_END = 3'b110
   } bcs_bus_state_type;
endpackage

//--- testbench/bcs_chk.sv
// assertions on the bus control pins of bcs_top
// assumes a bind to bcs_top by port name
`timescale 1ns/10ps
`default_nettype none
module bcs_chk
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic core_stop_instr,
   input wire logic independent_dma,
   input wire logic serial_channel_dma,
   input wire logic serial_dma_request,
   input wire logic irq_pending,
   input wire logic bus_clear_irq_en,
   input wire logic periph_base_write,
   input wire logic boot_select_n,
   input wire logic ram_select_n,
   input wire logic transfer_ack_n,
   input wire logic bus_fault_n,
   input wire logic bus_fault_oe,
   input wire logic dma_grant_ack_n,
   input wire logic bus_clear_oe,
   input wire logic stop_pin_oe,
   input wire logic core_run,
   input wire logic periph_respond,
   input wire logic [15:0] core_status_word
);
   logic based_q;
   // ----
   // base write seen since reset
   // ----
   always_ff @(posedge core_clk)
   begin
      if (rst)
         based_q <= 1'b0;
      else if (periph_base_write)
         based_q <= 1'b1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_fault_on_miss: assert property
      ($fell(bus_fault_n) |-> bus_fault_oe && boot_select_n && ram_select_n)
      else $error("fault during a hit");
   a_grant_in_dma: assert property
      ((independent_dma || serial_channel_dma) |=> !dma_grant_ack_n) else $error("no grant");
   a_stop_drive: assert property
      (core_stop_instr && core_run |=> stop_pin_oe) else $error("stop pin not driven");
   a_stop_gated: assert property
      (core_stop_instr && !core_run |=> !stop_pin_oe)
      else $error("stop pin driven while core is off");
   a_ack_in_hit: assert property
      ($fell(transfer_ack_n) |-> !boot_select_n || !ram_select_n) else $error("ack on miss");
   a_clear_on_req: assert property
      (serial_dma_request || (irq_pending && bus_clear_irq_en) |=> bus_clear_oe)
      else $error("bus clear missing");
   a_status_reset: assert property
      ($fell(rst) |-> core_status_word == 16'h2700) else $error("status word wrong");
   a_periph_gated: assert property
      (!based_q |-> !periph_respond) else $error("early peripheral answer");
   a_boot_wins: assert property
      (!boot_select_n |-> ram_select_n) else $error("both selects low");
endmodule // bcs_chk
`default_nettype wire

//--- testbench/bcs_mem_model.sv
// boot eprom and static ram on the two selects
// assumes both parts share address and byte strobes
`timescale 1ns/10ps
`default_nettype none
module bcs_mem_model
(
   input wire logic core_clk,
   input wire logic boot_select_n,
   input wire logic ram_select_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic [23:0] bus_addr,
   output logic [15:0] mem_data
);
   logic [15:0] word_d;
   logic [15:0] float_q = 16'h5A5A;
   logic sel;
   // an idle bus shows a pattern that flips every cycle
   assign sel = !boot_select_n || !ram_select_n;
   assign word_d = {(!boot_select_n) ? 4'hB : 4'hA, bus_addr[11:0]};
   assign mem_data[15:8] = (sel && !upper_byte_strobe_n) ? word_d[15:8] : float_q[15:8];
   assign mem_data[7:0] = (sel && !lower_byte_strobe_n) ? word_d[7:0] : float_q[7:0];
   always_ff @(posedge core_clk)
   begin
      float_q <= ~float_q;
   end
endmodule // bcs_mem_model
`default_nettype wire

//--- testbench/bcs_tb.sv
// self-checking bench for bcs_top with a memory model on the selects
// assumes bcs_chk and bcs_mem_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic core_clk, rst, addr_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, pin_rst_ext;
   logic bus_width_select, core_disable_pin, core_stop_instr, core_reset_instr, independent_dma;
   logic serial_channel_dma, serial_dma_request, irq_pending, bus_clear_irq_en, sel_write;
   logic ext_request_level7, ext_request_level6, ext_request_level1, sel_enable, periph_access;
   logic periph_base_write, int_vector_valid, core_run, wide_bus, periph_respond, bus_clear_n;
   logic boot_select_n, ram_select_n, transfer_ack_n, bus_fault_n, bus_fault_oe, dma_grant_ack_n;
   logic bus_clear_oe, stop_pin_out, stop_pin_oe, reset_pin_out, reset_pin_oe;
   logic stop_pin_in, reset_pin_in;
   logic [23:0] bus_addr, sel_base, sel_mask;
   logic [3:0] port_b_req, sel_wait, bus_state_dbg;
   logic [1:0] sel_target;
   logic [11:0] periph_base_value, periph_base;
   logic [15:0] core_status_word, mem_data;
   logic [6:0] request_sources;
   logic [7:0] int_vector;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   // open-drain pins: low while either side pulls
   assign stop_pin_in = !(pin_rst_ext || stop_pin_oe);
   assign reset_pin_in = !(pin_rst_ext || reset_pin_oe);
   bcs_top #(.WDOG_LIMIT(20)) dut_u (.*);
   bcs_mem_model mem_u (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // ----
   // helpers
   // ----
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic settle(input int n);
      tick(n);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic acc(input logic [23:0] a, input logic [1:0] want);
      logic [1:0] hit;
      int n;
      hit = 2'b00;
      n = 0;
      tick(1);
      bus_addr <= a;
      addr_strobe_n <= 1'b0;
      while (transfer_ack_n !== 1'b0 && bus_fault_n !== 1'b0 && n < 60)
      begin
         settle(1);
         n++;
         hit = hit | {!ram_select_n, !boot_select_n};
      end
      chk(hit, want);
      chk(transfer_ack_n, want == 2'b00);
      chk({bus_fault_n, bus_fault_oe}, {want != 2'b00, want == 2'b00});
      if (want != 2'b00)
         chk(mem_data, {(want == 2'b01) ? 4'hB : 4'hA, a[11:0]});
      tick(1);
      addr_strobe_n <= 1'b1;
      settle(6);
      chk({ram_select_n, boot_select_n, bus_fault_n}, 3'b111);
      chk(bus_state_dbg, {1'b1, bcs_pkg::BUS_IDLE});
   endtask
   task automatic t_cut;
      tick(1);
      bus_addr <= 24'h010000;
      addr_strobe_n <= 1'b0;
      tick(6);
      addr_strobe_n <= 1'b1;
      settle(6);
      chk({bus_fault_n, bus_state_dbg}, {1'b1, 1'b1, bcs_pkg::BUS_IDLE});
      acc(24'h000100, 2'b01);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_ram;
      tick(1);
      sel_write <= 1'b1;
      sel_target <= 2'h1;
      sel_mask <= 24'hFF0000;
      sel_enable <= 1'b1;
      sel_wait <= 4'h2;
      tick(1);
      sel_write <= 1'b0;
      acc(24'h000100, 2'b01);
      acc(24'h004000, 2'b10);
      acc(24'h010000, 2'b00);
   endtask
   task automatic t_pin_reset;
      tick(1);
      pin_rst_ext <= 1'b1;
      tick(6);
      pin_rst_ext <= 1'b0;
      settle(6);
      chk(core_status_word, 16'h2700);
      acc(24'h004000, 2'b00);
   endtask
   task automatic t_periph;
      tick(1);
      periph_access <= 1'b1;
      bus_addr <= 24'h700010;
      settle(4);
      chk(periph_respond, 1'b0);
      tick(1);
      periph_base_write <= 1'b1;
      periph_base_value <= 12'h700;
      tick(1);
      periph_base_write <= 1'b0;
      settle(3);
      chk({periph_respond, periph_base}, {1'b1, 12'h700});
   endtask
   task automatic t_ctrl;
      tick(1);
      independent_dma <= 1'b1;
      serial_dma_request <= 1'b1;
      irq_pending <= 1'b1;
      core_stop_instr <= 1'b1;
      settle(2);
      chk({dma_grant_ack_n, bus_clear_oe, stop_pin_oe}, 3'b011);
      tick(1);
      independent_dma <= 1'b0;
      serial_channel_dma <= 1'b1;
      serial_dma_request <= 1'b0;
      core_stop_instr <= 1'b0;
      core_reset_instr <= 1'b1;
      settle(2);
      chk({dma_grant_ack_n, bus_clear_oe, stop_pin_oe, reset_pin_oe}, 4'h1);
      tick(1);
      serial_channel_dma <= 1'b0;
      core_reset_instr <= 1'b0;
      bus_clear_irq_en <= 1'b1;
      core_disable_pin <= 1'b1;
      settle(6);
      chk({dma_grant_ack_n, bus_clear_oe, core_run}, 3'b110);
      tick(1);
      core_stop_instr <= 1'b1;
      settle(2);
      chk(stop_pin_oe, 1'b0);
      tick(1);
      {core_stop_instr, core_disable_pin, irq_pending, bus_clear_irq_en} <= 4'h0;
      settle(4);
      chk({core_run, stop_pin_oe, bus_clear_oe}, 3'b100);
      chk({bus_clear_n, stop_pin_out, reset_pin_out}, 3'b000);
   endtask
   task automatic t_irq;
      for (int i = 0; i < 7; i++)
      begin
         tick(1);
         {ext_request_level7, ext_request_level6, ext_request_level1, port_b_req} <= ~(7'h01 << i);
         settle(5);
         chk({int_vector_valid, int_vector}, {1'b1, bcs_pkg::VEC_BASE_RST, 2'b00, 3'(i + 1)});
         chk(request_sources, 7'h01 << i);
      end
   endtask
   initial
   begin
      {core_disable_pin, core_stop_instr, core_reset_instr, independent_dma, pin_rst_ext} = '0;
      {serial_channel_dma, serial_dma_request, irq_pending, bus_clear_irq_en, sel_write} = '0;
      {sel_target, sel_base, sel_mask, sel_enable, sel_wait, bus_addr} = '0;
      {periph_base_write, periph_base_value, periph_access} = '0;
      {upper_byte_strobe_n, lower_byte_strobe_n} = 2'b00;
      {ext_request_level7, ext_request_level6, ext_request_level1, port_b_req} = 7'h7F;
      bus_width_select = 1'b1;
      addr_strobe_n = 1'b1;
      rst = 1'b1;
      tick(12);
      rst <= 1'b0;
      settle(4);
      chk({core_status_word, wide_bus}, {16'h2700, 1'b1});
      acc(24'h001FFE, 2'b01);
      acc(24'h002000, 2'b00);
      acc(24'h004000, 2'b00);
      t_ram();
      t_pin_reset();
      t_cut();
      t_periph();
      t_ctrl();
      t_irq();
      tally_and_finish();
   end
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
endmodule // tb
bind bcs_top bcs_chk chk_u (.*);
`default_nettype wire
